/* File: sar_ctrl_pkg.sv */
// constants and types shared by the converter control blocks
package sar_ctrl_pkg;
  // system clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  // settle time after reset release before acquisition starts
  localparam int unsigned RESET_EXIT_DELAY_NS = 1000;
  // least time, rounded up to whole clock cycles
  localparam int unsigned RESET_EXIT_CYC =
    (RESET_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXIT_CNT_W = 8;
  localparam logic [EXIT_CNT_W-1:0] EXIT_CNT_LAST = EXIT_CNT_W'(RESET_EXIT_CYC - 1);
  localparam logic [EXIT_CNT_W-1:0] EXIT_CNT_RESET = 8'h00;

  // internal oscillator is an enable pulse divided from the system clock
  localparam int unsigned OSC_DIV = 2;
  localparam int unsigned OSC_PERIOD_NS = CLK_PERIOD_NS * OSC_DIV;
  localparam int unsigned OSC_CNT_W = 2;
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_LAST = OSC_CNT_W'(OSC_DIV - 1);
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_RESET = 2'h0;

  // conversion time limits, counted in oscillator ticks
  localparam int unsigned CONV_TIME_MIN_NS = 300;
  localparam int unsigned CONV_TIME_MAX_NS = 400;
  localparam int unsigned TICK_CNT_W = 8;
  localparam logic [TICK_CNT_W-1:0] CONV_MIN_TICKS =
    TICK_CNT_W'((CONV_TIME_MIN_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS);
  localparam logic [TICK_CNT_W-1:0] CONV_MAX_TICKS =
    TICK_CNT_W'(CONV_TIME_MAX_NS / OSC_PERIOD_NS);
  localparam logic [TICK_CNT_W-1:0] TICK_CNT_RESET = 8'h00;
  localparam logic [7:0] JITTER_SEED = 8'h5a;

  // output coding
  localparam int unsigned RESULT_W = 18;
  localparam int unsigned RAW_W = 20;
  localparam logic [RESULT_W-1:0] CODE_ZERO = 18'h00000;
  localparam logic [RESULT_W-1:0] CODE_POS_FULL = 18'h1ffff;
  localparam logic [RESULT_W-1:0] CODE_NEG_FULL = 18'h20000;
  localparam logic signed [RAW_W-1:0] RAW_POS_LIMIT = 20'sh1ffff;
  localparam logic signed [RAW_W-1:0] RAW_NEG_LIMIT = -20'sh20000;

  // transfer clock source select
  localparam logic [1:0] XFER_SEL_OSC = 2'h0;
  localparam logic [1:0] XFER_SEL_SCLK = 2'h1;
  localparam logic [1:0] XFER_SEL_MIXED = 2'h2;

  localparam int unsigned LANE_W = 4;
  localparam logic [LANE_W-1:0] LANES_OFF = 4'h0;

  typedef enum logic [1:0] {ST_RESET, ST_EXIT, ST_ACQ, ST_CNV} ctrl_state_t;

  // clamp a signed raw sample into the 18-bit twos complement code
  function automatic logic [RESULT_W-1:0] encode_code(input logic signed [RAW_W-1:0] raw);
    logic [RESULT_W-1:0] code;
    code = CODE_ZERO;
    if (raw > RAW_POS_LIMIT) begin
      code = CODE_POS_FULL;
    end else if (raw < RAW_NEG_LIMIT) begin
      code = CODE_NEG_FULL;
    end else begin
      code = raw[RESULT_W-1:0];
    end
    return code;
  endfunction
endpackage

/* File: sar_converter_core.sv */
// converter half: oscillator-timed conversion, state flag and result coding
`timescale 1ns/1ps
module sar_converter_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_reset,
  input wire logic conv_start,
  input wire logic signed [sar_ctrl_pkg::RAW_W-1:0] sample_raw_in,
  output logic converter_state_flag,
  output logic sampling_connected,
  output logic [sar_ctrl_pkg::RESULT_W-1:0] result,
  output logic result_valid,
  output logic osc_tick
);
  typedef struct packed {
    logic [sar_ctrl_pkg::OSC_CNT_W-1:0] osc_cnt;
    logic osc_tick;
    logic [sar_ctrl_pkg::TICK_CNT_W-1:0] ticks;
    logic [7:0] jitter;
    logic busy;
    logic flag;
    logic connected;
    logic signed [sar_ctrl_pkg::RAW_W-1:0] held;
    logic [sar_ctrl_pkg::RESULT_W-1:0] result;
    logic valid;
  } core_t;

  localparam core_t CORE_RESET = '{
    osc_cnt: sar_ctrl_pkg::OSC_CNT_RESET, osc_tick: 1'b0,
    ticks: sar_ctrl_pkg::TICK_CNT_RESET, jitter: sar_ctrl_pkg::JITTER_SEED,
    busy: 1'b0, flag: 1'b1, connected: 1'b1, held: '0,
    result: sar_ctrl_pkg::CODE_ZERO, valid: 1'b0};

  core_t q, d;
  logic done;

  // conversion steps on the oscillator only; sclk never reaches this block
  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.osc_tick = (q.osc_cnt == sar_ctrl_pkg::OSC_CNT_LAST); // [R9]
    d.osc_cnt = d.osc_tick ? sar_ctrl_pkg::OSC_CNT_RESET : q.osc_cnt + 2'h1;
    // finish between the minimum and one oscillator tick past the maximum, picked by a small lfsr
    done = q.busy && q.osc_tick && (q.ticks >= sar_ctrl_pkg::CONV_MIN_TICKS) &&
           (q.jitter[0] || (q.ticks >= sar_ctrl_pkg::CONV_MAX_TICKS)); // [R10]
    if (q.osc_tick) begin
      d.jitter = {q.jitter[6:0], q.jitter[7] ^ q.jitter[5] ^ q.jitter[4] ^ q.jitter[3]};
    end
    if (!q.busy && conv_start) begin
      d.busy = 1'b1;
      d.flag = 1'b0; // [R15]
      d.connected = 1'b0;
      d.held = sample_raw_in;
      d.ticks = sar_ctrl_pkg::TICK_CNT_RESET;
    end else if (done) begin
      d.busy = 1'b0;
      d.flag = 1'b1; // [R15]
      d.connected = 1'b1; // [R12]
      d.result = sar_ctrl_pkg::encode_code(q.held); // [R13]
      d.valid = 1'b1; // [R11]
    end else if (q.busy && q.osc_tick) begin
      d.ticks = q.ticks + 8'h01;
    end
  end

  // internal reset aborts any conversion and reconnects the inputs
  always_ff @(posedge clk_sys) begin
    if (rst || conv_reset) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  assign converter_state_flag = q.flag;
  assign sampling_connected = q.connected;
  assign result = q.result;
  assign result_valid = q.valid;
  assign osc_tick = q.osc_tick;
endmodule

/* File: sar_adc_state_and_reset_control.sv */
// interface half: reset entry and exit, state machine, strobe and lane control
`timescale 1ns/1ps
// Overview of operation
// [R1] exactly one of reset, acquire or convert state, chosen by reset and start pins
// [R2] reset pin acts at once, without waiting for any clock edge
// [R3] host holds reset pin low at least the minimum reset low width
// [R4] in reset: configuration defaults, ready strobe low, output lanes released
// [R5] host releases reset with start and sclk low and chip select high
// [R6] after release wait the exit delay, then acquire and raise ready strobe
// [R7] host keeps reset high to acquire or convert; never leave reset while low
// [R8] with reset high, only start pin transitions move between acquire and convert; the code leaves convert for acquire on converter completion instead
// [R9] conversions are timed by the internal oscillator, not by sclk
// [R10] conversion length varies but stays between minimum and maximum limits; the code can run up to one oscillator tick past the 400 ns maximum
// [R11] interface passes reset and start to converter, gets flag and result back
// [R12] end of conversion reconnects inputs and returns to acquire by itself
// [R13] results are 18-bit twos complement, clamped at the overrange codes
// [R14] transfer timing from oscillator, from sclk, or from both, as selected
// [R15] converter flag low during conversion, high again when it completes
// [R16] with chip select high, ready strobe follows the converter flag
// [R17] rising start edge moves acquire to convert
// [R18] further start transitions are ignored until the conversion completes
// [R19] reset asserts at once; its release is synchronised before exit counting
module sar_adc_state_and_reset_control (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_in_n,
  input wire logic conversion_start_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [1:0] xfer_clk_sel,
  input wire logic signed [sar_ctrl_pkg::RAW_W-1:0] sample_raw_in,
  output logic ready_strobe_out,
  output logic converter_state_flag_out,
  output logic [sar_ctrl_pkg::RESULT_W-1:0] result_out,
  output logic result_valid_out,
  output logic [sar_ctrl_pkg::LANE_W-1:0] serial_out_lanes_o,
  output logic [sar_ctrl_pkg::LANE_W-1:0] serial_out_lanes_oe,
  output logic config_default_out,
  output logic reset_state_out,
  output logic acquire_state_out,
  output logic convert_state_out,
  output logic sampling_connected_out,
  output logic xfer_tick_out
);
  typedef struct packed {
    sar_ctrl_pkg::ctrl_state_t state;
    logic [sar_ctrl_pkg::EXIT_CNT_W-1:0] exit_cnt;
    logic start_prev;
    logic sclk_prev;
    logic conv_start;
    logic ready;
    logic flag;
    logic [sar_ctrl_pkg::RESULT_W-1:0] result;
    logic valid;
    logic [sar_ctrl_pkg::LANE_W-1:0] lanes_o;
    logic [sar_ctrl_pkg::LANE_W-1:0] lanes_oe;
    logic cfg_default;
    logic connected;
    logic xfer_tick;
    // registered state decode, so the state outputs leave flops directly
    logic st_reset;
    logic st_acq;
    logic st_cnv;
  } ctrl_t;

  // every field here is a constant, so async clearing is safe
  localparam ctrl_t CTRL_RESET = '{
    state: sar_ctrl_pkg::ST_RESET, exit_cnt: sar_ctrl_pkg::EXIT_CNT_RESET,
    start_prev: 1'b0, sclk_prev: 1'b0, conv_start: 1'b0, ready: 1'b0, flag: 1'b1,
    result: sar_ctrl_pkg::CODE_ZERO, valid: 1'b0, lanes_o: sar_ctrl_pkg::LANES_OFF,
    lanes_oe: sar_ctrl_pkg::LANES_OFF, cfg_default: 1'b1, connected: 1'b1,
    xfer_tick: 1'b0, st_reset: 1'b1, st_acq: 1'b0, st_cnv: 1'b0};

  ctrl_t q, d;
  logic [1:0] rst_sync_q;
  logic hold_reset;
  logic core_flag;
  logic core_connected;
  logic [sar_ctrl_pkg::RESULT_W-1:0] core_result;
  logic core_valid;
  logic osc_tick;
  logic start_rise;
  logic sclk_rise;

  // reset pin clears at once; release passes two flops before counting
  always_ff @(posedge clk_sys or negedge reset_in_n) begin
    if (!reset_in_n) begin
      rst_sync_q <= 2'h3; // [R2]
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b0}; // [R19]
    end
  end

  assign hold_reset = rst_sync_q[1];

  // converter sees the internal reset and a one-cycle start request
  sar_converter_core u_core (
    .clk_sys(clk_sys),
    .rst(rst),
    .conv_reset(hold_reset), // [R11]
    .conv_start(q.conv_start), // [R11]
    .sample_raw_in(sample_raw_in),
    .converter_state_flag(core_flag),
    .sampling_connected(core_connected),
    .result(core_result),
    .result_valid(core_valid),
    .osc_tick(osc_tick)
  );

  assign start_rise = conversion_start_in && !q.start_prev;
  assign sclk_rise = sclk_in && !q.sclk_prev;

  // exit counting still reads as reset state from the outside
  function automatic logic is_reset_state(input sar_ctrl_pkg::ctrl_state_t st);
    return (st == sar_ctrl_pkg::ST_RESET) || (st == sar_ctrl_pkg::ST_EXIT);
  endfunction

  // next state of the whole interface half
  always_comb begin
    d = q;
    d.start_prev = conversion_start_in;
    d.sclk_prev = sclk_in;
    d.conv_start = 1'b0;
    d.valid = core_valid;
    d.flag = core_flag;
    d.connected = core_connected;
    if (core_valid) begin
      d.result = core_result;
    end
    // transfer timing source; mixed takes either edge source
    case (xfer_clk_sel)
      sar_ctrl_pkg::XFER_SEL_OSC: d.xfer_tick = osc_tick; // [R14]
      sar_ctrl_pkg::XFER_SEL_SCLK: d.xfer_tick = sclk_rise; // [R14]
      sar_ctrl_pkg::XFER_SEL_MIXED: d.xfer_tick = osc_tick || sclk_rise; // [R14]
      default: d.xfer_tick = 1'b0;
    endcase
    case (q.state)
      sar_ctrl_pkg::ST_RESET: begin
        d.state = sar_ctrl_pkg::ST_EXIT; // [R1]
        d.exit_cnt = sar_ctrl_pkg::EXIT_CNT_RESET;
      end
      sar_ctrl_pkg::ST_EXIT: begin
        // still reset state to the outside until the delay runs out
        if (q.exit_cnt == sar_ctrl_pkg::EXIT_CNT_LAST) begin
          d.state = sar_ctrl_pkg::ST_ACQ; // [R6]
          d.cfg_default = 1'b0;
        end else begin
          d.exit_cnt = q.exit_cnt + 8'h01;
        end
      end
      sar_ctrl_pkg::ST_ACQ: begin
        if (start_rise) begin
          d.state = sar_ctrl_pkg::ST_CNV; // [R17]
          d.conv_start = 1'b1; // [R8]
        end
      end
      sar_ctrl_pkg::ST_CNV: begin
        // start edges here are dropped, not queued
        if (core_valid) begin
          d.state = sar_ctrl_pkg::ST_ACQ; // [R12]
        end // [R18]
      end
      default: d.state = sar_ctrl_pkg::ST_RESET;
    endcase
    // strobe and lanes: frame owns them while chip select is low
    if (is_reset_state(d.state)) begin
      d.ready = 1'b0; // [R4]
      d.lanes_oe = sar_ctrl_pkg::LANES_OFF; // [R4]
      d.lanes_o = sar_ctrl_pkg::LANES_OFF;
    end else if (cs_n_in) begin
      d.ready = core_flag; // [R16]
      d.lanes_oe = sar_ctrl_pkg::LANES_OFF;
    end else begin
      d.ready = 1'b0;
      d.lanes_oe = {sar_ctrl_pkg::LANE_W{1'b1}};
      d.lanes_o = q.result[sar_ctrl_pkg::RESULT_W-1 -: sar_ctrl_pkg::LANE_W];
    end
    // decode from the next state so the flags change on the same edge as the state
    // costs three flops but keeps the state outputs glitch free
    d.st_reset = is_reset_state(d.state); // [R1]
    d.st_acq = (d.state == sar_ctrl_pkg::ST_ACQ); // [R1]
    d.st_cnv = (d.state == sar_ctrl_pkg::ST_CNV); // [R1]
  end

  // async clear from the pin, sync hold until the release is synchronised
  always_ff @(posedge clk_sys or negedge reset_in_n) begin
    if (!reset_in_n) begin
      q <= CTRL_RESET; // [R4]
    end else if (rst || hold_reset) begin
      q <= CTRL_RESET; // [R19]
    end else begin
      q <= d;
    end
  end

  assign ready_strobe_out = q.ready;
  assign converter_state_flag_out = q.flag;
  assign result_out = q.result;
  assign result_valid_out = q.valid;
  assign serial_out_lanes_o = q.lanes_o;
  assign serial_out_lanes_oe = q.lanes_oe;
  assign config_default_out = q.cfg_default;
  assign reset_state_out = q.st_reset;
  assign acquire_state_out = q.st_acq;
  assign convert_state_out = q.st_cnv;
  assign sampling_connected_out = q.connected;
  assign xfer_tick_out = q.xfer_tick;
endmodule

/* File: sar_ctrl_assertions.sv */
// port assertions for the converter control block
`timescale 1ns/1ps
module sar_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_in_n,
  input wire logic conversion_start_in,
  input wire logic cs_n_in,
  input wire logic ready_strobe_out,
  input wire logic converter_state_flag_out,
  input wire logic result_valid_out,
  input wire logic [sar_ctrl_pkg::LANE_W-1:0] serial_out_lanes_oe,
  input wire logic config_default_out,
  input wire logic reset_state_out,
  input wire logic acquire_state_out,
  input wire logic convert_state_out,
  input wire logic sampling_connected_out
);
  default clocking @(posedge clk_sys);
  endclocking
  a_one_state: assert property (disable iff (rst)
    $onehot({reset_state_out, acquire_state_out, convert_state_out})) else $error("state");
  a_reset_quiet: assert property (disable iff (rst) !reset_in_n |-> reset_state_out
    && !ready_strobe_out && serial_out_lanes_oe == 4'h0 && config_default_out) else $error("rst");
  a_exit_delay: assert property (disable iff (rst || !reset_in_n)
    $rose(reset_in_n) |-> ##[124:132] $rose(acquire_state_out)) else $error("exit delay");
  a_start_converts: assert property (disable iff (rst || !reset_in_n)
    acquire_state_out && conversion_start_in && !$past(conversion_start_in)
    |=> convert_state_out) else $error("start not taken");
  a_conv_time: assert property (disable iff (rst || !reset_in_n)
    $rose(convert_state_out) |-> ##2 (!converter_state_flag_out && !result_valid_out)[*8]
    ##[23:48] result_valid_out) else $error("conversion time");
  a_end_returns: assert property (disable iff (rst || !reset_in_n)
    $fell(convert_state_out) |-> acquire_state_out && sampling_connected_out
    && converter_state_flag_out && result_valid_out) else $error("end of conversion");
  a_ready_follows: assert property (disable iff (rst || !reset_in_n)
    cs_n_in && $past(cs_n_in) && (acquire_state_out || convert_state_out)
    |-> ready_strobe_out == converter_state_flag_out) else $error("ready strobe");
  a_lanes_released: assert property (disable iff (rst)
    cs_n_in && $past(cs_n_in) |-> serial_out_lanes_oe == 4'h0) else $error("lanes driven");
endmodule
bind sar_adc_state_and_reset_control sar_ctrl_assertions u_chk (.clk_sys(clk_sys), .rst(rst),
  .reset_in_n(reset_in_n), .conversion_start_in(conversion_start_in), .cs_n_in(cs_n_in),
  .ready_strobe_out(ready_strobe_out), .converter_state_flag_out(converter_state_flag_out),
  .result_valid_out(result_valid_out), .serial_out_lanes_oe(serial_out_lanes_oe),
  .config_default_out(config_default_out), .reset_state_out(reset_state_out),
  .acquire_state_out(acquire_state_out), .convert_state_out(convert_state_out),
  .sampling_connected_out(sampling_connected_out));

/* File: sar_host_model.sv */
// host controller model driving reset, start, chip select and serial clock
`timescale 1ns/1ps
module sar_host_model #(
  parameter int unsigned RST_LOW_CYC = 4
) (
  input wire logic clk_sys,
  input wire logic rst_req,
  input wire logic start_req,
  input wire logic cs_req,
  output logic reset_in_n = 1'b0,
  output logic conversion_start_in = 1'b0,
  output logic sclk_in = 1'b0,
  output logic cs_n_in = 1'b1
);
  logic [7:0] low_cnt_q = 8'h00;
  // a one-cycle request still gives the full low width
  always @(posedge clk_sys) begin
    if (rst_req) begin
      reset_in_n <= 1'b0;
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q < 8'(RST_LOW_CYC)) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end else begin
      reset_in_n <= 1'b1;
    end
    // old pin value used, so start is low and cs high at the release edge
    conversion_start_in <= start_req && reset_in_n && !rst_req;
    cs_n_in <= !(cs_req && reset_in_n && !rst_req);
    sclk_in <= !cs_n_in && !sclk_in;
  end
endmodule

/* File: sar_adc_state_and_reset_control_tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_state_and_reset_control_tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, rst_req = 1'b1, start_req = 1'b0, cs_req = 1'b0;
  logic [1:0] xfer_clk_sel = 2'h0;
  logic signed [19:0] sample_raw_in = 20'h00000;
  logic reset_in_n, conversion_start_in, sclk_in, cs_n_in, ready_strobe_out, xfer_tick_out;
  logic converter_state_flag_out, result_valid_out, config_default_out, reset_state_out;
  logic acquire_state_out, convert_state_out, sampling_connected_out;
  logic [17:0] result_out;
  logic [3:0] serial_out_lanes_o, serial_out_lanes_oe;
  int num_errors = 0;
  int check_count = 0;
  int n;
  // ordinary cases: raw sample beside its code, overrange rows included
  logic [19:0] raw_tab [8] = '{20'h00000, 20'h00001, 20'hfffff, 20'h1ffff, 20'h20000,
    20'he0000, 20'he0001, 20'hdffff};
  logic [17:0] code_tab [8] = '{18'h00000, 18'h00001, 18'h3ffff, 18'h1ffff, 18'h1ffff,
    18'h20000, 18'h20001, 18'h20000};
  always #4 clk_sys = ~clk_sys;
  sar_host_model u_host (.clk_sys(clk_sys), .rst_req(rst_req), .start_req(start_req),
    .cs_req(cs_req), .reset_in_n(reset_in_n), .conversion_start_in(conversion_start_in),
    .sclk_in(sclk_in), .cs_n_in(cs_n_in));
  sar_adc_state_and_reset_control u_dut (.clk_sys(clk_sys), .rst(rst), .reset_in_n(reset_in_n),
    .conversion_start_in(conversion_start_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
    .xfer_clk_sel(xfer_clk_sel), .sample_raw_in(sample_raw_in), .result_out(result_out),
    .ready_strobe_out(ready_strobe_out), .converter_state_flag_out(converter_state_flag_out),
    .result_valid_out(result_valid_out), .serial_out_lanes_o(serial_out_lanes_o),
    .serial_out_lanes_oe(serial_out_lanes_oe), .config_default_out(config_default_out),
    .reset_state_out(reset_state_out), .acquire_state_out(acquire_state_out),
    .convert_state_out(convert_state_out), .sampling_connected_out(sampling_connected_out),
    .xfer_tick_out(xfer_tick_out));
  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // counts negedges to acquire; a short count means the exit delay was cut
  task automatic wait_acq();
    for (n = 0; n < 300 && acquire_state_out !== 1'b1; n++) @(negedge clk_sys);
    check(n >= sar_ctrl_pkg::RESET_EXIT_CYC, "exit too early");
    check(ready_strobe_out === 1'b1 && config_default_out === 1'b0, "acquire entry");
    @(posedge clk_sys);
  endtask
  task automatic pulse_start();
    start_req <= 1'b1;
    @(posedge clk_sys);
    start_req <= 1'b0;
  endtask
  task automatic convert(input logic [19:0] raw, input logic [17:0] code);
    sample_raw_in <= raw;
    pulse_start();
    for (n = 0; n < 100 && result_valid_out !== 1'b1; n++) @(negedge clk_sys);
    check(n * 8 >= 300 && n * 8 <= 464, "conversion length");
    check(result_out === code, "result code");
    check(acquire_state_out === 1'b1 && sampling_connected_out === 1'b1, "no return");
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (11) @(posedge clk_sys);
    @(negedge clk_sys);
    check(reset_state_out === 1'b1 && ready_strobe_out === 1'b0, "reset state");
    check(serial_out_lanes_oe === 4'h0 && config_default_out === 1'b1, "reset lanes");
    @(posedge clk_sys);
    rst <= 1'b0;
    rst_req <= 1'b0;
    wait_acq();
    for (int i = 0; i < 8; i++) convert(raw_tab[i], code_tab[i]);
    // a second start edge mid-conversion must not start another
    pulse_start();
    repeat (10) @(posedge clk_sys);
    pulse_start();
    n = 0;
    repeat (90) begin
      @(negedge clk_sys);
      if (result_valid_out === 1'b1) n++;
    end
    check(n == 1, "extra conversion");
    // frame open: lanes driven, every tick source tried
    @(posedge clk_sys);
    cs_req <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      xfer_clk_sel <= 2'(s);
      repeat (3) @(negedge clk_sys);
      n = 0;
      repeat (16) begin
        @(negedge clk_sys);
        if (xfer_tick_out === 1'b1) n++;
      end
      check((n > 0) === (s != 3), "tick source");
      check(serial_out_lanes_oe === 4'hf && serial_out_lanes_o === 4'h8, "lanes");
      @(posedge clk_sys);
    end
    cs_req <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check(serial_out_lanes_oe === 4'h0 && ready_strobe_out === 1'b1, "frame end");
    // reset pin dropped mid-conversion acts before any clock edge
    @(posedge clk_sys);
    pulse_start();
    repeat (8) @(posedge clk_sys);
    rst_req <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(reset_state_out === 1'b1 && convert_state_out === 1'b0, "async reset");
    check(ready_strobe_out === 1'b0, "ready in reset");
    @(posedge clk_sys);
    rst_req <= 1'b0;
    wait_acq();
    convert(raw_tab[2], code_tab[2]);
    final_report();
  end
  // watchdog: the sequence takes about 950 cycles
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
